// File: rtl/simreg_bank.sv
// register bank of the dual card-slot multiplexer with input debouncers
`timescale 1ns/100ps
module simreg_debounce (
	// clock and reset
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	// timing tick and sampled input
	input  wire logic       tick,
	input  wire logic       din,
	input  wire logic [7:0] count,
	// accepted level and change pulse
	output logic            level_r,
	output logic            changed_r
);
	import simreg_pkg::*;
	logic [7:0] cnt_r;

	// counts stable ticks while the input differs from the accepted level
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r     <= SIMREG_RST_ZERO;
			level_r   <= 1'b0;
			changed_r <= 1'b0;
		end else begin
			changed_r <= 1'b0;
			if (din == level_r) begin
				cnt_r <= SIMREG_RST_ZERO; // glitch restarts the wait
			end else if (tick) begin
				// a count of zero acts as one: the compare fires on the first tick
				if (cnt_r + SIMREG_CNT_ONE >= count) begin // [RL11]
					level_r   <= din;
					changed_r <= 1'b1;
					cnt_r     <= SIMREG_RST_ZERO;
				end else begin
					cnt_r <= cnt_r + SIMREG_CNT_ONE;
				end
			end
		end
	end

	// an accepted change only ever follows a timing tick and flips the level
	AST_DEB_ON_TICK: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL11]
		changed_r |-> $past(tick))
		else $error("debounce change without a tick");
	AST_DEB_NEW_LVL: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL11]
		changed_r |-> level_r != $past(level_r))
		else $error("debounce change kept the old level");
	// the wait restarts whenever the input falls back to the accepted level
	AST_DEB_RESTART: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL11]
		din == level_r |=> cnt_r == SIMREG_RST_ZERO)
		else $error("debounce count kept after glitch");
endmodule

module simreg_bank #(
	parameter logic [3:0] MAKER_ID = 4'h5, // arbitrary value
	parameter logic [3:0] DEV_REV  = 4'h2, // arbitrary value
	parameter logic [7:0] DRV_VER  = 8'h3C // arbitrary value
) (
	// clock and reset
	input  wire logic                  clk_sys,
	input  wire logic                  rst_n,
	// register access from the serial front end
	input  wire simreg_pkg::simreg_req_t req,
	output logic [7:0]                 rdata_r,
	output logic                       rvalid_r,
	// sensed inputs
	input  wire logic                  timing_tick,
	input  wire logic                  shutdown_request_input,
	input  wire logic                  battery_sense_input,
	// control outputs
	output simreg_pkg::simreg_slot_t   card_slot_one_r,
	output simreg_pkg::simreg_slot_t   card_slot_two_r,
	output logic                       clk_src_sel_r,
	output logic [7:0]                 dev_ctl_r,
	output logic [1:0]                 pull_ctl_r,
	output logic [7:0]                 status_r
);
	import simreg_pkg::*;

	logic [7:0] bat_deb_r;
	logic [7:0] sdn_deb_r;
	logic [7:0] slot_ctl_r;
	logic [7:0] clk_ctl_r;
	logic [7:0] pull_r;
	logic       sdn_lvl;
	logic       sdn_chg;
	logic       bat_lvl;
	logic       bat_chg;
	logic       sdn_st_r;
	logic       sdn_irq_r;
	logic       bat_irq_r;
	logic [7:0] status_nxt;
	logic [7:0] rd_nxt;

	simreg_debounce u_sdn_deb (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.tick      (timing_tick),
		.din       (shutdown_request_input),
		.count     (sdn_deb_r),
		.level_r   (sdn_lvl),
		.changed_r (sdn_chg)
	);

	simreg_debounce u_bat_deb (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.tick      (timing_tick),
		.din       (battery_sense_input),
		.count     (bat_deb_r),
		.level_r   (bat_lvl),
		.changed_r (bat_chg)
	);

	// slot status mapping: active needs regulator on, off regulator means down
	function automatic logic [1:0] slot_stat(input logic [1:0] st, input logic en);
		logic [1:0] r;
		r = SIMREG_SLOT_DOWN; // regulator off pulls the slot down whatever is asked
		if (en) begin
			unique case (st)
				SIMREG_SLOT_DOWN:   r = SIMREG_SLOT_PWR; // [RL8] [RL9]
				SIMREG_SLOT_ISO:    r = SIMREG_SLOT_ISO;
				SIMREG_SLOT_PWR:    r = SIMREG_SLOT_PWR; // forbidden request, still coded
				SIMREG_SLOT_ACTIVE: r = SIMREG_SLOT_ACTIVE; // [RL8] [RL9]
			endcase
		end
		return r;
	endfunction

	wire logic wr_hit = req.wr;
	wire logic status_rd = req.rd && (req.addr == SIMREG_OFS_STATUS);

	// the two per-slot nibbles of the interface control register
	simreg_slot_t slot_one;
	simreg_slot_t slot_two;
	assign slot_one = slot_ctl_r[SIMREG_SLOT1_POS +: SIMREG_SLOT_W];
	assign slot_two = slot_ctl_r[SIMREG_SLOT2_POS +: SIMREG_SLOT_W];

	// writable registers
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			slot_ctl_r <= SIMREG_RST_ZERO;
			bat_deb_r  <= SIMREG_RST_DEB; // [RL4]
			sdn_deb_r  <= SIMREG_RST_DEB; // [RL5]
			clk_ctl_r  <= SIMREG_RST_ZERO;
			dev_ctl_r  <= SIMREG_RST_ZERO;
			pull_r     <= SIMREG_RST_ZERO;
		end else if (wr_hit) begin
			unique case (req.addr)
				SIMREG_OFS_SLOTCTL: slot_ctl_r <= req.wdata;
				SIMREG_OFS_BATDEB:  bat_deb_r  <= req.wdata; // [RL4]
				SIMREG_OFS_SDNDEB:  sdn_deb_r  <= req.wdata; // [RL5]
				SIMREG_OFS_CLKCTL:  clk_ctl_r  <= req.wdata & SIMREG_CLKCTL_MASK; // [RL6]
				SIMREG_OFS_DEVCTL:  dev_ctl_r  <= req.wdata;
				SIMREG_OFS_PULL:    pull_r     <= req.wdata & SIMREG_PULL_MASK;
				default: ; // identity, status, reserved and test range ignore writes
			endcase
		end
	end

	// a debounce count write lands on the edge that takes the strobe
	AST_BAT_WR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL4]
		req.wr && req.addr == SIMREG_OFS_BATDEB |=> bat_deb_r == $past(req.wdata))
		else $error("battery count not written");
	// reserved pull bits never keep a written one
	AST_PULL_RSVD: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(pull_r & ~SIMREG_PULL_MASK) == SIMREG_RST_ZERO)
		else $error("reserved pull bits set");

	// event flags: set wins over the clear caused by a status read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sdn_st_r  <= 1'b0;
			sdn_irq_r <= 1'b0;
			bat_irq_r <= 1'b0;
		end else begin
			if (sdn_chg) begin
				sdn_st_r <= sdn_lvl; // [RL10]
			end
			sdn_irq_r <= sdn_chg | (sdn_irq_r & ~status_rd); // [RL7] [RL10]
			bat_irq_r <= (bat_chg & bat_lvl) | (bat_irq_r & ~status_rd); // [RL7]
		end
	end

	// a read on the event edge must not swallow the event
	AST_IRQ_WINS: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
		sdn_chg && status_rd |=> sdn_irq_r)
		else $error("event lost to a status read");
	AST_BAT_IRQ_SET: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
		bat_chg && bat_lvl |=> bat_irq_r)
		else $error("removal flag not set");
	AST_BAT_IRQ_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
		status_rd && !bat_chg |=> !bat_irq_r)
		else $error("read did not clear removal flag");

	// status image assembled from live state
	always_comb begin
		status_nxt = SIMREG_RST_ZERO;
		status_nxt[SIMREG_ST_SDN]     = sdn_st_r;
		status_nxt[SIMREG_ST_SDN_IRQ] = sdn_irq_r;
		status_nxt[SIMREG_ST_BAT]     = bat_lvl;
		status_nxt[SIMREG_ST_BAT_IRQ] = bat_irq_r;
		status_nxt[SIMREG_ST_SLOT1 +: SIMREG_SLOT_ST_W] = // [RL9]
			slot_stat(slot_one.state, slot_one.ldo_en);
		status_nxt[SIMREG_ST_SLOT2 +: SIMREG_SLOT_ST_W] = // [RL9]
			slot_stat(slot_two.state, slot_two.ldo_en);
	end

	// isolated and powered states need the regulator on as well
	AST_SLOT_ISO: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL8]
		slot_one.ldo_en && slot_one.state == SIMREG_SLOT_ISO
		|-> status_nxt[5:4] == SIMREG_SLOT_ISO)
		else $error("slot one not isolated");
	AST_SLOT_PWR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL8]
		slot_two.ldo_en && slot_two.state == SIMREG_SLOT_DOWN
		|-> status_nxt[7:6] == SIMREG_SLOT_PWR)
		else $error("slot two not powered");
	AST_SLOT_ONE_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL9]
		!slot_one.ldo_en
		|-> status_nxt[5:4] == SIMREG_SLOT_DOWN)
		else $error("slot one not down with regulator off");

	// read mux; unmapped and test range read as zero
	// the status image is taken before the same-edge clear, so a read sees its flags
	always_comb begin
		unique case (req.addr)
			SIMREG_OFS_IDENT:   rd_nxt = {MAKER_ID, DEV_REV}; // [RL1] [RL2] [RL3]
			SIMREG_OFS_DRVVER:  rd_nxt = DRV_VER;
			SIMREG_OFS_STATUS:  rd_nxt = status_nxt;
			SIMREG_OFS_SLOTCTL: rd_nxt = slot_ctl_r;
			SIMREG_OFS_BATDEB:  rd_nxt = bat_deb_r;
			SIMREG_OFS_SDNDEB:  rd_nxt = sdn_deb_r;
			SIMREG_OFS_CLKCTL:  rd_nxt = clk_ctl_r;
			SIMREG_OFS_DEVCTL:  rd_nxt = dev_ctl_r;
			SIMREG_OFS_PULL:    rd_nxt = pull_r;
			default:            rd_nxt = SIMREG_RST_ZERO;
		endcase
	end

	// registered outputs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r         <= SIMREG_RST_ZERO;
			rvalid_r        <= 1'b0;
			status_r        <= SIMREG_RST_ZERO;
			card_slot_one_r <= '0;
			card_slot_two_r <= '0;
			clk_src_sel_r   <= 1'b0;
			pull_ctl_r      <= 2'h0;
		end else begin
			rvalid_r        <= req.rd;
			if (req.rd) begin
				rdata_r <= rd_nxt;
			end
			status_r        <= status_nxt;
			card_slot_one_r <= slot_one;
			card_slot_two_r <= slot_two;
			clk_src_sel_r   <= clk_ctl_r[SIMREG_CLKCTL_SEL]; // [RL6]
			pull_ctl_r      <= pull_r[SIMREG_PULL_POS +: SIMREG_PULL_W];
		end
	end

	// the read answer comes one cycle after the strobe and lasts one cycle
	AST_RD_PULSE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		req.rd |=> rvalid_r)
		else $error("read answer missing");
	AST_RD_ONCE: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!req.rd |=> !rvalid_r)
		else $error("read answer without a strobe");
	AST_CLK_SEL: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL6]
		req.wr && req.addr == SIMREG_OFS_CLKCTL
		|=> ##1 clk_src_sel_r == $past(req.wdata[SIMREG_CLKCTL_SEL], 2))
		else $error("clock source select not taken");

	// register map checks; each watches what the bank itself drives
	AST_DEB_RESET: assert property (@(posedge clk_sys) $rose(rst_n) |-> // [RL4]
		bat_deb_r == SIMREG_RST_DEB && sdn_deb_r == SIMREG_RST_DEB)
		else $error("debounce counts not four after reset");
	AST_IDENT: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL1]
		req.rd && req.addr == SIMREG_OFS_IDENT |=> rdata_r == {MAKER_ID, DEV_REV})
		else $error("identity read wrong");
	AST_MAKER_NIB: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL2]
		req.rd && req.addr == SIMREG_OFS_IDENT |=> rdata_r[7:4] == MAKER_ID)
		else $error("maker nibble wrong");
	AST_IDENT_RO: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL3]
		req.wr && req.addr == SIMREG_OFS_IDENT ##2 req.rd && req.addr == SIMREG_OFS_IDENT
		|=> rdata_r[7:4] == MAKER_ID)
		else $error("maker nibble changed by write");
	AST_SDN_WR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL5]
		req.wr && req.addr == SIMREG_OFS_SDNDEB |=> sdn_deb_r == $past(req.wdata))
		else $error("shutdown count not written");
	AST_CLK_RSVD: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL6]
		##1 clk_ctl_r[6:0] == 7'h00)
		else $error("reserved clock bits set");
	AST_IRQ_CLR: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
		status_rd && !sdn_chg |=> !sdn_irq_r)
		else $error("read did not clear flag");
	AST_IRQ_SET: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL7]
		sdn_chg |=> sdn_irq_r ##1 status_r[SIMREG_ST_SDN_IRQ])
		else $error("flag not set on event");
	AST_SLOT_ACT: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL8]
		status_nxt[5:4] == SIMREG_SLOT_ACTIVE |-> slot_ctl_r[3:2] == SIMREG_SLOT_ACTIVE)
		else $error("slot one active without request");
	AST_SLOT_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL9]
		!slot_ctl_r[4] |-> status_nxt[7:6] == SIMREG_SLOT_DOWN)
		else $error("slot two not down with regulator off");
	AST_SDN_CAP: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL10]
		sdn_chg |=> sdn_st_r == $past(sdn_lvl))
		else $error("shutdown level not captured");
	AST_DEB_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // [RL11]
		sdn_chg |-> $past(shutdown_request_input) == sdn_lvl)
		else $error("shutdown accepted without stable input");
endmodule

// File: common/simreg_pkg.sv
// package of constants and types for the card-slot multiplexer register bank
// Overview of operation
// [RL1] identity register at command 00h is read-only and encodes maker and device.
// [RL2] maker identity sits in the upper nibble, device and revision in the lower.
// [RL3] maker nibble stays fixed across revisions; only the revision part changes.
// [RL4] battery-sense debounce count at 0Ah is read/write, resets to four.
// [RL5] shutdown debounce count at 0Bh is read/write, resets to four.
// [RL6] clock control at 0Dh has source select in bit 7, rest reserved.
// [RL7] status interrupt flags set on their event and clear when status is read.
// [RL8] slot status field: 00 powered down, 11 active, 01 isolated, 10 powered.
// [RL9] slot reports active only with active state requested and regulator enabled.
// [RL10] shutdown status bit samples the input level when its debounce expires.
// [RL11] debounce counts timing-clock ticks; change accepted after programmed stable ticks.
package simreg_pkg;
	localparam logic [7:0] SIMREG_OFS_IDENT    = 8'h00;
	localparam logic [7:0] SIMREG_OFS_DRVVER   = 8'h01;
	localparam logic [7:0] SIMREG_OFS_STATUS   = 8'h04;
	localparam logic [7:0] SIMREG_OFS_SLOTCTL  = 8'h08;
	localparam logic [7:0] SIMREG_OFS_BATDEB   = 8'h0A;
	localparam logic [7:0] SIMREG_OFS_SDNDEB   = 8'h0B;
	localparam logic [7:0] SIMREG_OFS_RSVD     = 8'h0C;
	localparam logic [7:0] SIMREG_OFS_CLKCTL   = 8'h0D;
	localparam logic [7:0] SIMREG_OFS_DEVCTL   = 8'h0E;
	localparam logic [7:0] SIMREG_OFS_TEST_LO  = 8'h10;
	localparam logic [7:0] SIMREG_OFS_TEST_HI  = 8'h14;
	localparam logic [7:0] SIMREG_OFS_PULL     = 8'h15;
	localparam logic [7:0] SIMREG_RST_ZERO     = 8'h00;
	localparam logic [7:0] SIMREG_RST_DEB      = 8'h04;
	localparam logic [7:0] SIMREG_CLKCTL_MASK  = 8'h80;
	localparam logic [7:0] SIMREG_PULL_MASK    = 8'h03;
	localparam logic [7:0] SIMREG_CNT_ONE      = 8'h01;
	// field positions in the status register
	localparam int SIMREG_ST_SDN      = 0;
	localparam int SIMREG_ST_SDN_IRQ  = 1;
	localparam int SIMREG_ST_BAT      = 2;
	localparam int SIMREG_ST_BAT_IRQ  = 3;
	localparam int SIMREG_ST_SLOT1    = 4;
	localparam int SIMREG_ST_SLOT2    = 6;
	localparam int SIMREG_SLOT_ST_W   = 2;
	// field positions in the control registers
	localparam int SIMREG_SLOT1_POS   = 0;
	localparam int SIMREG_SLOT2_POS   = 4;
	localparam int SIMREG_SLOT_W      = 4;
	localparam int SIMREG_CLKCTL_SEL  = 7;
	localparam int SIMREG_PULL_POS    = 0;
	localparam int SIMREG_PULL_W      = 2;
	// slot status encodings
	localparam logic [1:0] SIMREG_SLOT_DOWN   = 2'h0;
	localparam logic [1:0] SIMREG_SLOT_ISO    = 2'h1;
	localparam logic [1:0] SIMREG_SLOT_PWR    = 2'h2;
	localparam logic [1:0] SIMREG_SLOT_ACTIVE = 2'h3;
	// one register access from the serial port front end
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} simreg_req_t;
	// per-slot control field: state, voltage select, regulator enable
	typedef struct packed {
		logic [1:0] state;
		logic       vsel;
		logic       ldo_en;
	} simreg_slot_t;
endpackage

// File: bench/simreg_host.sv
// host model issuing single-byte register reads and writes to the bank
`timescale 1ns/100ps
module simreg_host (
	// clock
	input  wire logic               clk_sys,
	// register access toward the bank
	output simreg_pkg::simreg_req_t req,
	input  wire logic [7:0]         rdata_r,
	input  wire logic               rvalid_r
);
	import simreg_pkg::*;
	// bus idle from time zero
	initial req = '{wr: 1'b0, rd: 1'b0, addr: 8'hFF, wdata: 8'h00};
	// one-cycle write strobe launched off the sampling edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		req.addr = a;
		req.wdata = d;
		req.wr = 1'b1;
		@(negedge clk_sys);
		req.wr = 1'b0;
		req.wdata = ~d; // stale data never reused
	endtask
	// one-cycle read strobe; answer awaited a bounded number of cycles
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		int n;
		@(negedge clk_sys);
		req.addr = a;
		req.rd = 1'b1;
		@(negedge clk_sys);
		req.rd = 1'b0;
		n = 0;
		while (rvalid_r !== 1'b1 && n < 4) begin
			@(negedge clk_sys);
			n++;
		end
		d = (rvalid_r === 1'b1) ? rdata_r : 8'hXX;
	endtask
endmodule

// File: bench/sim_mux_register_map_bench.sv
// self-checking bench of the card-slot multiplexer register bank
`timescale 1ns/100ps
module sim_mux_register_map_bench;
	import simreg_pkg::*;
	localparam logic [3:0] MK = 4'h9; // arbitrary value
	localparam logic [3:0] RV = 4'h6; // arbitrary value
	localparam logic [7:0] DV = 8'h7E; // arbitrary value
	logic clk_sys, rst_n, timing_tick, sdn_in, bat_in, rvalid_r, clk_src_sel_r;
	logic [7:0] rdata_r, dev_ctl_r, status_r;
	logic [1:0] pull_ctl_r;
	simreg_req_t req;
	simreg_slot_t card_slot_one_r, card_slot_two_r;
	int n_errors = 0;
	int cmp_count = 0;
	int cycles = 0;
	simreg_bank #(.MAKER_ID(MK), .DEV_REV(RV), .DRV_VER(DV)) i_simreg_bank (.clk_sys(clk_sys),
		.rst_n(rst_n), .req(req), .rdata_r(rdata_r), .rvalid_r(rvalid_r),
		.timing_tick(timing_tick), .shutdown_request_input(sdn_in),
		.battery_sense_input(bat_in), .card_slot_one_r(card_slot_one_r),
		.card_slot_two_r(card_slot_two_r), .clk_src_sel_r(clk_src_sel_r),
		.dev_ctl_r(dev_ctl_r), .pull_ctl_r(pull_ctl_r), .status_r(status_r));
	simreg_host i_simreg_host (.clk_sys(clk_sys), .req(req), .rdata_r(rdata_r),
		.rvalid_r(rvalid_r));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// read a register and compare the masked bits only
	task automatic rchk(input string nm, input logic [7:0] a, m, e);
		logic [7:0] d;
		i_simreg_host.rd(a, d);
		chk(nm, e & m, d & m);
	endtask
	// timing-clock ticks, then settle time for the flag update
	task automatic ticks(input int k);
		repeat (k) begin
			@(negedge clk_sys);
			timing_tick = 1'b1;
			@(negedge clk_sys);
			timing_tick = 1'b0;
		end
		repeat (3) @(negedge clk_sys);
	endtask
	task automatic t_reset();
		logic [7:0] ofs [11] = '{8'h00, 8'h01, 8'h04, 8'h08, 8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E,
			8'h15, 8'h30};
		logic [7:0] exv [11] = '{{MK, RV}, DV, 8'h00, 8'h00, 8'h04, 8'h04, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00};
		for (int i = 0; i < 11; i++) rchk("reset value", ofs[i], 8'hFF, exv[i]);
		$display("test reset done");
	endtask
	task automatic t_rw();
		i_simreg_host.wr(8'h00, 8'hA5);
		rchk("identity after write", 8'h00, 8'hFF, {MK, RV});
		i_simreg_host.wr(8'h0C, 8'hA5);
		i_simreg_host.wr(8'h12, 8'hA5);
		i_simreg_host.wr(8'h0A, 8'hA5);
		i_simreg_host.wr(8'h0B, 8'h5A);
		i_simreg_host.wr(8'h0D, 8'hFF);
		i_simreg_host.wr(8'h15, 8'hFF);
		i_simreg_host.wr(8'h0E, 8'h5A);
		rchk("identity", 8'h00, 8'hF0, {MK, 4'h0});
		rchk("identity low", 8'h00, 8'h0F, {4'h0, RV});
		rchk("reserved", 8'h0C, 8'hFF, 8'h00);
		rchk("battery count", 8'h0A, 8'hFF, 8'hA5);
		rchk("shutdown count", 8'h0B, 8'hFF, 8'h5A);
		rchk("clock control", 8'h0D, 8'hFF, 8'h80);
		chk("clock select", 8'h01, {7'h00, clk_src_sel_r});
		rchk("pull control", 8'h15, 8'hFF, 8'h03);
		chk("pull out", 8'h03, {6'h00, pull_ctl_r});
		rchk("device control", 8'h0E, 8'hFF, 8'h5A);
		chk("device control out", 8'h5A, dev_ctl_r);
		$display("test write access done");
	endtask
	task automatic t_slot();
		logic [1:0] e;
		for (int n = 0; n < 16; n++) begin
			i_simreg_host.wr(8'h08, {n[3:0], n[3:0]});
			e = !n[0] ? SIMREG_SLOT_DOWN : (n[3:2] == 2'b00) ? SIMREG_SLOT_PWR : n[3:2];
			rchk("slot status", 8'h04, 8'hF0, {e, e, 4'h0});
			chk("slot ctl", {n[3:0], n[3:0]}, {card_slot_two_r, card_slot_one_r});
			chk("status image", {e, e, 4'h0}, status_r);
		end
		i_simreg_host.wr(8'h08, 8'h00);
		$display("test slot status done");
	endtask
	task automatic t_bat();
		i_simreg_host.wr(8'h0A, 8'h03);
		bat_in = 1'b1;
		ticks(2);
		rchk("battery early", 8'h04, 8'h0C, 8'h00);
		ticks(1);
		rchk("battery removed", 8'h04, 8'h0C, 8'h0C);
		rchk("battery flag clear", 8'h04, 8'h0C, 8'h04);
		bat_in = 1'b0;
		ticks(3);
		rchk("battery back", 8'h04, 8'h0C, 8'h00);
		$display("test battery debounce done");
	endtask
	task automatic t_sdn();
		i_simreg_host.wr(8'h0B, 8'h02);
		sdn_in = 1'b1;
		ticks(1);
		rchk("shutdown early", 8'h04, 8'h03, 8'h00);
		ticks(1);
		rchk("shutdown high", 8'h04, 8'h03, 8'h03);
		rchk("shutdown flag clear", 8'h04, 8'h03, 8'h01);
		sdn_in = 1'b0;
		ticks(2);
		rchk("shutdown low", 8'h04, 8'h03, 8'h02);
		$display("test shutdown debounce done");
	endtask
	// an event and a status read on the same edge: the flag must survive
	task automatic t_race();
		i_simreg_host.wr(8'h0B, 8'h01);
		sdn_in = 1'b1;
		fork
			begin
				@(negedge clk_sys);
				timing_tick = 1'b1;
				@(negedge clk_sys);
				timing_tick = 1'b0;
			end
			begin
				@(negedge clk_sys);
				rchk("race read", 8'h04, 8'h03, 8'h00);
			end
		join
		rchk("race flag kept", 8'h04, 8'h03, 8'h03);
		$display("test read and event race done");
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	// free-running system clock
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// hang guard: far above the roughly two hundred cycles the tests need
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			final_report();
		end
	end
	// main sequence
	initial begin
		rst_n = 1'b0;
		timing_tick = 1'b0;
		sdn_in = 1'b0;
		bat_in = 1'b0;
		repeat (8) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		t_reset();
		t_rw();
		t_slot();
		t_bat();
		t_sdn();
		t_race();
		final_report();
	end
endmodule
